/* logic/cpu_link_pkg.sv */
// Purpose: Shared constants, states and parity helper for the CPU link
// Assumes: One 250 MHz bus clock shared by both ends
// Notes: Pin levels on the link are active low unless named otherwise
package cpu_link_pkg;
	localparam int CLK_PERIOD_NS = 4;
	localparam int POR_HOLD_NS = 1000000;
	localparam int WARM_HOLD_NS = 1000;
	// Least times round up to whole cycles
	localparam int POR_HOLD_CYCLES =
		(POR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WARM_HOLD_CYCLES =
		(WARM_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STRAP_HOLD_CYCLES = 4;
	localparam int BUILTIN_SELF_TEST_CYCLES = 64;
	localparam logic [35:0] RESET_VECTOR = 36'h0_FFFF_FFF0;
	localparam int CMD_W = 5;
	localparam int RATIO_W = 4;

	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] RESP_OFS = 8'h08;
	localparam logic [7:0] REQ_OFS = 8'h0C;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam int CTRL_PWR_BIT = 0;
	localparam int CTRL_WARM_BIT = 1;
	localparam int CTRL_INIT_BIT = 2;
	localparam int CTRL_TRI_BIT = 3;
	localparam int CTRL_PRI_BIT = 4;
	localparam int CTRL_RATIO_LSB = 8;
	localparam int CTRL_RUN_LSB = 12;
	localparam int STAT_RST_BIT = 0;
	localparam int STAT_OWN_BIT = 1;
	localparam int STAT_LOCK_BIT = 2;
	localparam int STAT_HIT_BIT = 3;
	localparam int STAT_BUSY_BIT = 4;

	typedef enum logic [2:0] {
		DS_OFF, DS_RESET, DS_BUILTIN_SELF_TEST, DS_RUN, DS_INIT, DS_TRISTATE
	} dev_state_e;
	typedef enum logic [1:0] {RQ_IDLE, RQ_A, RQ_B, RQ_WAIT} req_state_e;
	typedef enum logic [2:0] {
		HS_OFF, HS_POR, HS_WARM, HS_STRAP, HS_RUN
	} host_state_e;

	// High when an even number of the covered lines are low
	function automatic logic bus_parity(input logic [5:0] lines);
		return ~(^(~lines));
	endfunction
endpackage

/* logic/cpu_link_if.sv */
// Purpose: Pins between the processor front end and the chipset
// Assumes: Undriven shared lines are pulled high
// Notes: Shared lines resolve as wired-AND of every enabled driver
`timescale 1ns/100ps
interface cpu_link_if;
	logic power_stable;
	logic reset_n;
	logic init_n;
	logic addr_bit20_mask_n;
	logic ignore_numeric_error_n;
	logic [1:0] local_irq_pins;
	logic outputs_off_strap_n;
	logic priority_bus_request_n;
	logic irq_bus_clock;
	logic [2:0] response_status_n;
	logic response_parity_n;
	logic lock_n_o, lock_n_oe;
	logic hit_n_o, hit_n_oe;
	logic dev_ads_o, dev_ads_oe, dev_rp_o, dev_rp_oe, dev_req_oe;
	logic [4:0] dev_req_o;
	logic cs_ads_o, cs_ads_oe, cs_rp_o, cs_rp_oe, cs_req_oe;
	logic [4:0] cs_req_o;
	logic lock_n, hit_n, address_strobe_n, request_parity_n;
	logic [4:0] request_cmd_n;

	assign lock_n = ~lock_n_oe | lock_n_o;
	assign hit_n = ~hit_n_oe | hit_n_o;
	assign address_strobe_n = (~dev_ads_oe | dev_ads_o) &
		(~cs_ads_oe | cs_ads_o);
	assign request_parity_n = (~dev_rp_oe | dev_rp_o) &
		(~cs_rp_oe | cs_rp_o);
	assign request_cmd_n = ({5{~dev_req_oe}} | dev_req_o) &
		({5{~cs_req_oe}} | cs_req_o);

	modport dev (
		input power_stable, reset_n, init_n, addr_bit20_mask_n,
		input ignore_numeric_error_n, local_irq_pins, outputs_off_strap_n,
		input priority_bus_request_n, response_status_n, response_parity_n,
		input lock_n, address_strobe_n, request_cmd_n, request_parity_n,
		output lock_n_o, lock_n_oe, hit_n_o, hit_n_oe,
		output dev_ads_o, dev_ads_oe, dev_req_o, dev_req_oe,
		output dev_rp_o, dev_rp_oe
	);
	modport chipset (
		output power_stable, reset_n, init_n, addr_bit20_mask_n,
		output ignore_numeric_error_n, local_irq_pins, outputs_off_strap_n,
		output priority_bus_request_n, irq_bus_clock,
		output response_status_n, response_parity_n,
		output cs_ads_o, cs_ads_oe, cs_req_o, cs_req_oe, cs_rp_o, cs_rp_oe,
		input lock_n, hit_n, address_strobe_n, request_cmd_n,
		input request_parity_n
	);
endinterface

/* logic/cpu_front_end.sv */
// Purpose: Processor reset, init, configuration and request front end
// Assumes: Link bus lines are on hclk; init and strap pins are async
// Notes: Core-side pulses last one cycle; levels hold until changed
// Function
// - Soft init clears integer state only
// - After init, fetch from configured reset vector
// - Keep answering snoops during init
// - Init active at reset release runs self test
// - Controller off: pin0 maskable, pin1 nonmaskable
// - Local interrupt controller enabled out of reset
// - Sample ratio pins in reset, latch on release
// - Lock held from first through last transaction
// - Priority agent waits for lock released
// - Interrupt bus clock is quarter bus clock
// - Power rise followed by 1 ms reset
// - Request command driven over two cycles
// - Hard reset invalidates caches without writeback
// - Reset held 1 us warm, 1 ms cold
// - Outputs released within two clocks of reset
// - Tristate strap floats outputs, skips self test
// - Fetch starts at reset vector after reset
// - Request parity covers strobe and command lines
// - Parity high when even count of lows
// - Response parity covers status, high when idle
`timescale 1ns/100ps
module cpu_front_end #(
	parameter int BUILTIN_SELF_TEST_LEN = cpu_link_pkg::BUILTIN_SELF_TEST_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	cpu_link_if.dev link,
	input wire logic req_valid,
	input wire logic [9:0] req_cmd,
	input wire logic req_lock,
	input wire logic req_last,
	input wire logic snoop_hit,
	input wire logic lic_cfg_wr,
	input wire logic lic_cfg_en,
	output logic req_ready,
	output logic resp_done,
	output logic resp_err,
	output logic core_hold,
	output logic int_clear,
	output logic cache_inval,
	output logic fetch_start,
	output logic [35:0] fetch_addr,
	output logic [3:0] clock_ratio,
	output logic irq_maskable,
	output logic irq_nmi,
	output logic [1:0] lint_out
);
	typedef struct packed {
		logic [1:0] pwr_sy;
		logic [1:0] init_sy;
		logic [1:0] a20_sy;
		logic [1:0] ign_sy;
		logic [1:0] l0_sy;
		logic [1:0] l1_sy;
		logic rst_prev;
		cpu_link_pkg::dev_state_e st;
		cpu_link_pkg::req_state_e rq;
		logic [15:0] cnt;
		logic [3:0] ratio;
		logic [35:0] vector;
		logic lic_en;
		logic [9:0] cmd;
		logic locked;
		logic last;
		logic lock_o, lock_oe, hit_o, hit_oe;
		logic ads_o, ads_oe, rp_o, rp_oe, req_oe;
		logic [4:0] req_o;
		logic req_ready, resp_done, resp_err;
		logic core_hold, int_clear, cache_inval, fetch_start;
		logic irq_maskable, irq_nmi;
		logic [1:0] lint_out;
	} dev_s;

	localparam dev_s DEV_RST = '{
		st: cpu_link_pkg::DS_OFF, rq: cpu_link_pkg::RQ_IDLE,
		rst_prev: 1'b0, lic_en: 1'b1, core_hold: 1'b1,
		lock_o: 1'b1, hit_o: 1'b1, ads_o: 1'b1, rp_o: 1'b1,
		req_o: 5'h1F, vector: cpu_link_pkg::RESET_VECTOR, default: '0
	};

	dev_s q;
	dev_s n;
	logic init_act;
	logic snoop_seen;

	always_comb begin
		n = q;
		n.pwr_sy = {q.pwr_sy[0], link.power_stable};
		n.init_sy = {q.init_sy[0], link.init_n};
		n.a20_sy = {q.a20_sy[0], link.addr_bit20_mask_n};
		n.ign_sy = {q.ign_sy[0], link.ignore_numeric_error_n};
		n.l0_sy = {q.l0_sy[0], link.local_irq_pins[0]};
		n.l1_sy = {q.l1_sy[0], link.local_irq_pins[1]};
		n.rst_prev = link.reset_n;
		n.int_clear = 1'b0;
		n.cache_inval = 1'b0;
		n.fetch_start = 1'b0;
		n.resp_done = 1'b0;
		n.resp_err = 1'b0;
		n.hit_oe = 1'b0;
		n.hit_o = 1'b1;
		init_act = ~q.init_sy[1];
		snoop_seen = ~link.address_strobe_n & ~q.ads_oe;
		if (!q.pwr_sy[1]) begin
			// Nothing else is trusted until the supplies are good
			n = DEV_RST;
			n.pwr_sy = {q.pwr_sy[0], link.power_stable};
		end else if (!link.reset_n) begin
			n.st = cpu_link_pkg::DS_RESET;
			n.rq = cpu_link_pkg::RQ_IDLE;
			n.core_hold = 1'b1;
			// Invalidate once per reset, never write back
			n.cache_inval = q.st != cpu_link_pkg::DS_RESET;
			// Release registered here, so pins float one edge later
			n.ads_oe = 1'b0;
			n.req_oe = 1'b0;
			n.rp_oe = 1'b0;
			n.lock_oe = 1'b0;
			n.lock_o = 1'b1;
			n.locked = 1'b0;
			n.req_ready = 1'b0;
			n.lic_en = 1'b1;
			n.irq_maskable = 1'b0;
			n.irq_nmi = 1'b0;
			n.lint_out = 2'b00;
			// Follows the pins while reset lasts, frozen at release
			n.ratio = {q.l1_sy[1], q.l0_sy[1], q.ign_sy[1],
				q.a20_sy[1]};
		end else if (!q.rst_prev) begin
			n.vector = cpu_link_pkg::RESET_VECTOR;
			n.cnt = '0;
			if (!link.outputs_off_strap_n) begin
				// Strap wins over the self-test request
				n.st = cpu_link_pkg::DS_TRISTATE;
			end else if (init_act) begin
				n.st = cpu_link_pkg::DS_BUILTIN_SELF_TEST;
			end else begin
				n.st = cpu_link_pkg::DS_RUN;
				n.core_hold = 1'b0;
				n.fetch_start = 1'b1;
			end
		end else begin
			unique case (q.st)
				cpu_link_pkg::DS_OFF, cpu_link_pkg::DS_RESET,
				cpu_link_pkg::DS_TRISTATE: begin
					n.st = q.st;
				end
				cpu_link_pkg::DS_BUILTIN_SELF_TEST: begin
					n.cnt = q.cnt + 16'h0001;
					if (q.cnt == 16'(BUILTIN_SELF_TEST_LEN - 1)) begin
						n.st = cpu_link_pkg::DS_RUN;
						n.core_hold = 1'b0;
						n.fetch_start = 1'b1;
					end
				end
				cpu_link_pkg::DS_RUN: begin
					if (init_act) begin
						// Caches and floating-point state are left alone
						n.st = cpu_link_pkg::DS_INIT;
						n.int_clear = 1'b1;
						n.core_hold = 1'b1;
					end
				end
				cpu_link_pkg::DS_INIT: begin
					if (!init_act) begin
						n.st = cpu_link_pkg::DS_RUN;
						n.core_hold = 1'b0;
						n.fetch_start = 1'b1;
					end
				end
			endcase
			if (q.st == cpu_link_pkg::DS_RUN ||
				q.st == cpu_link_pkg::DS_INIT) begin
				if (snoop_seen) begin
					n.hit_oe = 1'b1;
					n.hit_o = ~snoop_hit;
				end
				if (lic_cfg_wr) begin
					n.lic_en = lic_cfg_en;
				end
				if (q.lic_en) begin
					n.lint_out = {q.l1_sy[1], q.l0_sy[1]};
					n.irq_maskable = 1'b0;
					n.irq_nmi = 1'b0;
				end else begin
					n.lint_out = 2'b00;
					n.irq_maskable = q.l0_sy[1];
					n.irq_nmi = q.l1_sy[1];
				end
				unique case (q.rq)
					cpu_link_pkg::RQ_IDLE: begin
						// Ownership is ours unless the priority agent
						// asks while none of our own locked sequences is open
						n.req_ready = q.st == cpu_link_pkg::DS_RUN &&
							(link.priority_bus_request_n || q.locked);
						if (req_valid && q.req_ready) begin
							n.req_ready = 1'b0;
							n.cmd = req_cmd;
							n.last = req_last;
							n.rq = cpu_link_pkg::RQ_A;
							n.ads_oe = 1'b1;
							n.ads_o = 1'b0;
							n.req_oe = 1'b1;
							n.req_o = req_cmd[4:0];
							n.rp_oe = 1'b1;
							n.rp_o = cpu_link_pkg::bus_parity(
								{1'b0, req_cmd[4:0]});
							if (req_lock || q.locked) begin
								n.locked = 1'b1;
								n.lock_oe = 1'b1;
								n.lock_o = 1'b0;
							end
						end
					end
					cpu_link_pkg::RQ_A: begin
						n.rq = cpu_link_pkg::RQ_B;
						n.ads_o = 1'b1;
						n.req_o = q.cmd[9:5];
						n.rp_o = cpu_link_pkg::bus_parity(
							{1'b1, q.cmd[9:5]});
					end
					cpu_link_pkg::RQ_B: begin
						n.rq = cpu_link_pkg::RQ_WAIT;
						n.ads_oe = 1'b0;
						n.req_oe = 1'b0;
						n.rp_oe = 1'b0;
					end
					cpu_link_pkg::RQ_WAIT: begin
						if (link.response_status_n != 3'b111) begin
							n.rq = cpu_link_pkg::RQ_IDLE;
							n.resp_done = 1'b1;
							n.resp_err = link.response_parity_n !=
								cpu_link_pkg::bus_parity({3'b111,
								link.response_status_n});
							if (q.last) begin
								// Lock drops only with the last answer
								n.locked = 1'b0;
								n.lock_oe = 1'b0;
								n.lock_o = 1'b1;
							end
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= DEV_RST;
		end else begin
			q <= n;
		end
	end

	assign link.lock_n_o = q.lock_o;
	assign link.lock_n_oe = q.lock_oe;
	assign link.hit_n_o = q.hit_o;
	assign link.hit_n_oe = q.hit_oe;
	assign link.dev_ads_o = q.ads_o;
	assign link.dev_ads_oe = q.ads_oe;
	assign link.dev_req_o = q.req_o;
	assign link.dev_req_oe = q.req_oe;
	assign link.dev_rp_o = q.rp_o;
	assign link.dev_rp_oe = q.rp_oe;
	assign req_ready = q.req_ready;
	assign resp_done = q.resp_done;
	assign resp_err = q.resp_err;
	assign core_hold = q.core_hold;
	assign int_clear = q.int_clear;
	assign cache_inval = q.cache_inval;
	assign fetch_start = q.fetch_start;
	assign fetch_addr = q.vector;
	assign clock_ratio = q.ratio;
	assign irq_maskable = q.irq_maskable;
	assign irq_nmi = q.irq_nmi;
	assign lint_out = q.lint_out;
endmodule

/* logic/chipset_seq.sv */
// Purpose: Chipset end: power and reset sequencing, straps, bus agent
// Assumes: Software drives it over AHB-Lite, zero wait states
// Notes: Register writes land in the data phase of the transfer
`timescale 1ns/100ps
module chipset_seq #(
	parameter int POR_CYCLES = cpu_link_pkg::POR_HOLD_CYCLES,
	parameter int WARM_CYCLES = cpu_link_pkg::WARM_HOLD_CYCLES,
	parameter int STRAP_CYCLES = cpu_link_pkg::STRAP_HOLD_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	cpu_link_if.chipset link
);
	localparam int CNT_W = $clog2(POR_CYCLES + 1);

	typedef struct packed {
		cpu_link_pkg::host_state_e hs;
		cpu_link_pkg::req_state_e rq;
		logic [CNT_W-1:0] cnt;
		logic [31:0] ctrl;
		logic owned, hit_last, wr_pend;
		logic [7:0] wr_addr;
		logic [9:0] cmd;
		logic [31:0] rdata;
		logic [1:0] div;
		logic pwr, rst_n, init_n, a20_n, ign_n, off_n, pri_n;
		logic [1:0] lint;
		logic [2:0] rs_n;
		logic rsp_n;
		logic ads_o, ads_oe, rp_o, rp_oe, req_oe;
		logic [4:0] req_o;
	} host_s;

	localparam host_s HOST_RST = '{
		hs: cpu_link_pkg::HS_OFF, rq: cpu_link_pkg::RQ_IDLE,
		ctrl: cpu_link_pkg::CTRL_RST, init_n: 1'b1, a20_n: 1'b1,
		ign_n: 1'b1, off_n: 1'b1, pri_n: 1'b1, lint: 2'b11,
		rs_n: 3'b111, rsp_n: 1'b1, ads_o: 1'b1, rp_o: 1'b1,
		req_o: 5'h1F, default: '0
	};

	host_s q;
	host_s n;
	logic [31:0] c;
	logic in_reset;

	always_comb begin
		n = q;
		n.div = q.div + 2'b01;
		n.rs_n = 3'b111;
		n.rsp_n = 1'b1;
		n.rdata = q.rdata;
		n.wr_pend = 1'b0;
		if (q.wr_pend && q.wr_addr == cpu_link_pkg::CTRL_OFS) begin
			n.ctrl = hwdata;
			n.ctrl[cpu_link_pkg::CTRL_WARM_BIT] = 1'b0;
		end
		c = n.ctrl;
		if (hsel && hready && htrans[1]) begin
			n.wr_pend = hwrite;
			n.wr_addr = haddr;
			if (!hwrite) begin
				unique case (haddr)
					cpu_link_pkg::CTRL_OFS: n.rdata = q.ctrl;
					cpu_link_pkg::STAT_OFS: begin
						n.rdata = '0;
						n.rdata[cpu_link_pkg::STAT_RST_BIT] = ~q.rst_n;
						n.rdata[cpu_link_pkg::STAT_OWN_BIT] = q.owned;
						n.rdata[cpu_link_pkg::STAT_LOCK_BIT] = ~link.lock_n;
						n.rdata[cpu_link_pkg::STAT_HIT_BIT] = q.hit_last;
						n.rdata[cpu_link_pkg::STAT_BUSY_BIT] =
							q.rq != cpu_link_pkg::RQ_IDLE;
					end
					default: n.rdata = '0;
				endcase
			end
		end
		n.pwr = c[cpu_link_pkg::CTRL_PWR_BIT];
		unique case (q.hs)
			cpu_link_pkg::HS_OFF: begin
				n.cnt = '0;
				if (c[cpu_link_pkg::CTRL_PWR_BIT]) begin
					n.hs = cpu_link_pkg::HS_POR;
				end
			end
			cpu_link_pkg::HS_POR, cpu_link_pkg::HS_WARM: begin
				n.cnt = q.cnt + CNT_W'(1);
				// Each power rise gets the full cold hold
				if ((q.hs == cpu_link_pkg::HS_POR &&
					q.cnt == CNT_W'(POR_CYCLES - 1)) ||
					(q.hs == cpu_link_pkg::HS_WARM &&
					q.cnt == CNT_W'(WARM_CYCLES - 1))) begin
					n.hs = cpu_link_pkg::HS_STRAP;
					n.cnt = '0;
				end
			end
			cpu_link_pkg::HS_STRAP: begin
				// Straps outlast the release so the far synchroniser
				// still sees them at its frozen edge
				n.cnt = q.cnt + CNT_W'(1);
				if (q.cnt == CNT_W'(STRAP_CYCLES - 1)) begin
					n.hs = cpu_link_pkg::HS_RUN;
				end
			end
			cpu_link_pkg::HS_RUN: begin
				if (c[cpu_link_pkg::CTRL_WARM_BIT] ||
					(q.wr_pend && q.wr_addr == cpu_link_pkg::CTRL_OFS &&
					hwdata[cpu_link_pkg::CTRL_WARM_BIT])) begin
					n.hs = cpu_link_pkg::HS_WARM;
					n.cnt = '0;
				end
			end
		endcase
		if (!c[cpu_link_pkg::CTRL_PWR_BIT]) begin
			n.hs = cpu_link_pkg::HS_OFF;
		end
		in_reset = n.hs != cpu_link_pkg::HS_STRAP &&
			n.hs != cpu_link_pkg::HS_RUN;
		n.rst_n = ~in_reset;
		if (n.hs == cpu_link_pkg::HS_RUN) begin
			// Ratio pins handed back to normal use
			{n.lint, n.ign_n, n.a20_n} =
				c[cpu_link_pkg::CTRL_RUN_LSB +: 4];
		end else begin
			{n.lint, n.ign_n, n.a20_n} =
				c[cpu_link_pkg::CTRL_RATIO_LSB +: 4];
		end
		n.init_n = ~c[cpu_link_pkg::CTRL_INIT_BIT];
		n.off_n = ~c[cpu_link_pkg::CTRL_TRI_BIT];
		n.pri_n = ~c[cpu_link_pkg::CTRL_PRI_BIT];
		// Ownership only once the lock has let go
		n.owned = ~q.pri_n & (q.owned | link.lock_n);
		if (q.wr_pend && q.wr_addr == cpu_link_pkg::RESP_OFS &&
			hwdata[2:0] != 3'b000) begin
			n.rs_n = ~hwdata[2:0];
			n.rsp_n = cpu_link_pkg::bus_parity(
				{3'b111, ~hwdata[2:0]});
		end
		unique case (q.rq)
			cpu_link_pkg::RQ_IDLE: begin
				if (q.wr_pend && q.wr_addr == cpu_link_pkg::REQ_OFS &&
					q.owned) begin
					n.cmd = hwdata[9:0];
					n.rq = cpu_link_pkg::RQ_A;
					n.ads_oe = 1'b1;
					n.ads_o = 1'b0;
					n.req_oe = 1'b1;
					n.req_o = hwdata[4:0];
					n.rp_oe = 1'b1;
					n.rp_o = cpu_link_pkg::bus_parity(
						{1'b0, hwdata[4:0]});
				end
			end
			cpu_link_pkg::RQ_A: begin
				n.rq = cpu_link_pkg::RQ_B;
				n.ads_o = 1'b1;
				n.req_o = q.cmd[9:5];
				n.rp_o = cpu_link_pkg::bus_parity({1'b1, q.cmd[9:5]});
			end
			cpu_link_pkg::RQ_B, cpu_link_pkg::RQ_WAIT: begin
				n.hit_last = ~link.hit_n;
				n.rq = cpu_link_pkg::RQ_IDLE;
				n.ads_oe = 1'b0;
				n.req_oe = 1'b0;
				n.rp_oe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= HOST_RST;
		end else begin
			q <= n;
		end
	end

	assign hrdata = q.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign link.irq_bus_clock = q.div[1];
	assign link.power_stable = q.pwr;
	assign link.reset_n = q.rst_n;
	assign link.init_n = q.init_n;
	assign link.addr_bit20_mask_n = q.a20_n;
	assign link.ignore_numeric_error_n = q.ign_n;
	assign link.local_irq_pins = q.lint;
	assign link.outputs_off_strap_n = q.off_n;
	assign link.priority_bus_request_n = q.pri_n;
	assign link.response_status_n = q.rs_n;
	assign link.response_parity_n = q.rsp_n;
	assign link.cs_ads_o = q.ads_o;
	assign link.cs_ads_oe = q.ads_oe;
	assign link.cs_req_o = q.req_o;
	assign link.cs_req_oe = q.req_oe;
	assign link.cs_rp_o = q.rp_o;
	assign link.cs_rp_oe = q.rp_oe;
endmodule

/* dv/cpu_link_sva.sv */
// Purpose: Wire checks on the link between front end and chipset
// Assumes: One clock domain; hresetn is asynchronous, active low
// Notes: Parity is recomputed here from the lines themselves
`timescale 1ns/100ps
module cpu_link_sva (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic power_stable,
	input wire logic reset_n,
	input wire logic lock_n,
	input wire logic lock_n_oe,
	input wire logic hit_n_oe,
	input wire logic dev_ads_oe,
	input wire logic dev_req_oe,
	input wire logic cs_ads_oe,
	input wire logic priority_bus_request_n,
	input wire logic irq_bus_clock,
	input wire logic address_strobe_n,
	input wire logic [4:0] request_cmd_n,
	input wire logic request_parity_n,
	input wire logic [2:0] response_status_n,
	input wire logic response_parity_n
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic dev_off;
	assign dev_off = !(lock_n_oe | hit_n_oe | dev_ads_oe | dev_req_oe);
	chk_parity_first: assert property (
		!address_strobe_n |-> request_parity_n == !(^{1'b1, ~request_cmd_n}))
		else $error("request parity wrong in first cycle");
	chk_parity_second: assert property (
		$past(!address_strobe_n) && address_strobe_n |->
		request_parity_n == !(^(~request_cmd_n)))
		else $error("request parity wrong in second cycle");
	chk_cmd_two_cycles: assert property (
		$fell(address_strobe_n) |=> address_strobe_n ##1
		request_cmd_n == 5'h1F)
		else $error("request not two cycles then released");
	chk_reset_quiet: assert property (
		!reset_n [*3] |-> dev_off)
		else $error("outputs driven two clocks into reset");
	chk_irq_clock: assert property (
		$rose(irq_bus_clock) |=> !$rose(irq_bus_clock) [*3] ##1
		$rose(irq_bus_clock))
		else $error("interrupt bus clock not a quarter rate");
	chk_resp_parity: assert property (
		response_parity_n == !(^(~response_status_n)))
		else $error("response parity wrong");
	chk_lock_start: assert property (
		$fell(lock_n) |-> $fell(address_strobe_n))
		else $error("lock not raised with first strobe");
	chk_lock_end: assert property (
		$rose(lock_n) |-> $past(response_status_n != 3'h7) ||
		$past(response_status_n != 3'h7, 2))
		else $error("lock released before a response");
	chk_pri_wait: assert property (
		$rose(cs_ads_oe) |-> !priority_bus_request_n && lock_n)
		else $error("chipset took bus while locked");
	chk_power_low: assert property (
		!power_stable |-> !reset_n)
		else $error("reset released without power");
	chk_power_reset: assert property (
		$rose(power_stable) |-> !reset_n [*8])
		else $error("power rise not followed by reset");
	cover property ($fell(lock_n));
	cover property ($rose(cs_ads_oe));
	cover property ($rose(reset_n) && power_stable);
endmodule

/* dv/test_cpu_reset_init_bus_parity.sv */
// Purpose: Bench joining the front end and the chipset over the link
// Assumes: Chipset slave answers with no wait states
// Notes: Long counts shortened by parameters; expectations follow them
`timescale 1ns/100ps
module test_cpu_reset_init_bus_parity;
	localparam int BL = 16;
	logic hclk = 1'h0;
	logic hresetn = 1'h0;
	logic hwrite = 1'h0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0, hrdata, q;
	logic hreadyout, hresp, req_ready, resp_done, resp_err, core_hold;
	logic req_valid = 1'h0, req_lock = 1'h0, req_last = 1'h0;
	logic snoop_hit = 1'h0, lic_cfg_wr = 1'h0, lic_cfg_en = 1'h1;
	logic [9:0] req_cmd = 10'h000;
	logic int_clear, cache_inval, fetch_start, irq_maskable, irq_nmi;
	logic [35:0] fetch_addr;
	logic [3:0] clock_ratio;
	logic [1:0] lint_out;
	logic [4:0] cap_a, cap_b;
	logic ads_d = 1'h1;
	logic last_err = 1'h0;
	int n_mismatch = 0, comparisons = 0, cyc = 0;
	int n_fetch = 0, n_done = 0, n_inval = 0, n_clr = 0;
	cpu_link_if link ();
	cpu_front_end #(.BUILTIN_SELF_TEST_LEN(BL)) i_cpu_front_end (.hclk(hclk),
		.hresetn(hresetn), .link(link), .req_valid(req_valid),
		.req_cmd(req_cmd), .req_lock(req_lock), .req_last(req_last),
		.snoop_hit(snoop_hit), .lic_cfg_wr(lic_cfg_wr),
		.lic_cfg_en(lic_cfg_en), .req_ready(req_ready),
		.resp_done(resp_done), .resp_err(resp_err), .core_hold(core_hold),
		.int_clear(int_clear), .cache_inval(cache_inval),
		.fetch_start(fetch_start), .fetch_addr(fetch_addr),
		.clock_ratio(clock_ratio), .irq_maskable(irq_maskable),
		.irq_nmi(irq_nmi), .lint_out(lint_out));
	chipset_seq #(.POR_CYCLES(20), .WARM_CYCLES(8), .STRAP_CYCLES(4))
		i_chipset_seq (.hclk(hclk), .hresetn(hresetn), .hsel(1'h1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .link(link));
	cpu_link_sva i_cpu_link_sva (.hclk(hclk), .hresetn(hresetn),
		.power_stable(link.power_stable), .reset_n(link.reset_n),
		.lock_n(link.lock_n), .lock_n_oe(link.lock_n_oe),
		.hit_n_oe(link.hit_n_oe), .dev_ads_oe(link.dev_ads_oe),
		.dev_req_oe(link.dev_req_oe), .cs_ads_oe(link.cs_ads_oe),
		.priority_bus_request_n(link.priority_bus_request_n),
		.irq_bus_clock(link.irq_bus_clock),
		.address_strobe_n(link.address_strobe_n),
		.request_cmd_n(link.request_cmd_n),
		.request_parity_n(link.request_parity_n),
		.response_status_n(link.response_status_n),
		.response_parity_n(link.response_parity_n));
	always #2 hclk = ~hclk;
	// Pulses are counted here so that no scenario can miss one mid-task
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		n_fetch <= n_fetch + (fetch_start === 1'h1);
		// Error flag lands on the same edge as the count that wakes the waiting task
		if (resp_done === 1'h1)
			last_err <= resp_err;
		n_done <= n_done + (resp_done === 1'h1);
		n_inval <= n_inval + (cache_inval === 1'h1);
		n_clr <= n_clr + (int_clear === 1'h1);
		if (link.address_strobe_n === 1'h0)
			cap_a <= link.request_cmd_n;
		if (ads_d === 1'h0)
			cap_b <= link.request_cmd_n;
		ads_d <= link.address_strobe_n;
		if (cyc == 6000) begin
			n_mismatch++;
			end_sim();
		end
	end
	task automatic end_sim();
		if (n_mismatch == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge hclk);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		q = hrdata;
	endtask
	// Straps ratio 4'hA, run levels 4'hD; low bits pri,tri,init,warm,pwr
	task automatic ctrl(input logic [4:0] b);
		ahb(1'h1, cpu_link_pkg::CTRL_OFS, {16'h0000, 4'hD, 4'hA, 3'h0, b});
	endtask
	task automatic t_power();
		ctrl(5'h01);
		wait (n_fetch == 1);
		chk(n_inval, 1);
		chk(fetch_addr, cpu_link_pkg::RESET_VECTOR);
		chk(clock_ratio, 4'hA);
		repeat (12) @(posedge hclk);
		chk({core_hold, irq_maskable, lint_out}, 4'h3);
		ahb(1'h0, 8'h40, 32'h0);
		chk(q, 32'h0);
	endtask
	task automatic t_lic();
		for (int e = 0; e < 2; e++) begin
			@(posedge hclk);
			lic_cfg_en <= e[0];
			lic_cfg_wr <= 1'h1;
			@(posedge hclk);
			lic_cfg_wr <= 1'h0;
			repeat (3) @(posedge hclk);
			chk({irq_nmi, irq_maskable, lint_out}, e ? 4'h3 : 4'hC);
		end
	endtask
	task automatic dev_req(input logic [9:0] c, input logic last);
		int k;
		k = n_done;
		@(posedge hclk);
		req_valid <= 1'h1;
		req_cmd <= c;
		req_lock <= 1'h1;
		req_last <= last;
		do @(posedge hclk); while (req_ready !== 1'h1);
		req_valid <= 1'h0;
		repeat (4) @(posedge hclk);
		chk({cap_b, cap_a}, c);
		ahb(1'h1, cpu_link_pkg::RESP_OFS, 32'h1);
		wait (n_done == k + 1);
		chk(last_err, 1'h0);
	endtask
	task automatic t_lock();
		dev_req(10'h2A5, 1'h0);
		chk(link.lock_n, 1'h0);
		dev_req(10'h15A, 1'h1);
		repeat (3) @(posedge hclk);
		chk(link.lock_n, 1'h1);
	endtask
	task automatic t_init();
		int f;
		f = n_fetch;
		snoop_hit <= 1'h1;
		ctrl(5'h15);
		repeat (6) @(posedge hclk);
		chk({core_hold, n_clr[3:0], n_fetch == f}, 6'h23);
		do ahb(1'h0, cpu_link_pkg::STAT_OFS, 32'h0); while (q[1] !== 1'h1);
		ahb(1'h1, cpu_link_pkg::REQ_OFS, 32'h0000_0193);
		repeat (8) @(posedge hclk);
		chk({cap_b, cap_a}, 10'h193);
		ahb(1'h0, cpu_link_pkg::STAT_OFS, 32'h0);
		chk(q[3], 1'h1);
		ctrl(5'h01);
		wait (n_fetch == f + 1);
		chk(fetch_addr, cpu_link_pkg::RESET_VECTOR);
		chk(n_inval, 1);
	endtask
	// The init bit is dropped only after release so that it is sampled
	task automatic t_reset(input logic [4:0] b, input int runs);
		int f;
		f = n_fetch;
		ctrl(b);
		wait (link.reset_n === 1'h0);
		wait (link.reset_n === 1'h1);
		ctrl(5'h01);
		repeat (BL + 24) @(posedge hclk);
		chk(n_fetch - f, runs);
		chk({link.lock_n_oe, link.hit_n_oe, link.dev_ads_oe,
			link.dev_req_oe}, 4'h0);
		chk(n_inval, b[3] ? 3 : 2);
	endtask
	task automatic t_builtin_self_test();
		int f, c;
		f = n_fetch;
		ctrl(5'h07);
		wait (link.reset_n === 1'h0);
		wait (link.reset_n === 1'h1);
		c = cyc;
		ctrl(5'h01);
		wait (n_fetch == f + 1);
		chk((cyc - c) inside {[BL:BL + 8]}, 1'h1);
		chk(n_inval, 2);
	endtask
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'h1;
		t_power();
		t_lic();
		t_lock();
		t_init();
		t_builtin_self_test();
		t_reset(5'h0F, 0);
		chk(core_hold, 1'h1);
		ctrl(5'h00);
		repeat (4) @(posedge hclk);
		chk({core_hold, req_ready, link.reset_n}, 3'h4);
		end_sim();
	end
endmodule
